// >>> src/rrdac_defs.svh
// register offsets, field positions, reset values and widths for the reference ladder control
`ifndef RRDAC_DEFS_SVH
`define RRDAC_DEFS_SVH
// ----------------------------------------------------------------
// register map (byte addresses, one word each)
// ----------------------------------------------------------------
`define RRDAC_OFS_CONTROL 4'h0
`define RRDAC_OFS_LEVEL 4'h4
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RRDAC_BIT_ENABLE 7
`define RRDAC_BIT_LPS 6
`define RRDAC_BIT_OE 5
`define RRDAC_PSS_HI 3
`define RRDAC_PSS_LO 2
`define RRDAC_CODE_HI 4
`define RRDAC_CODE_LO 0
// ----------------------------------------------------------------
// write masks and reset values
// ----------------------------------------------------------------
`define RRDAC_CONTROL_MASK 8'hEC
`define RRDAC_LEVEL_MASK 8'h1F
`define RRDAC_CONTROL_RST 8'h00
`define RRDAC_LEVEL_RST 8'h00
`define RRDAC_CODE_ONES 5'h1F
`define RRDAC_CODE_ZERO 5'h00
`define RRDAC_LEVELS 32
`endif

// >>> src/rrdac_pkg.sv
// types shared by the reference ladder control files
package rrdac_pkg;
	typedef enum logic [1:0] {
		RRDAC_SRC_SUPPLY = 2'b00,
		RRDAC_SRC_EXTREF = 2'b01,
		RRDAC_SRC_FIXREF = 2'b10,
		RRDAC_SRC_RSVD = 2'b11
	} rrdac_src_t;
	typedef enum logic [1:0] {
		RRDAC_BUS_IDLE = 2'b00,
		RRDAC_BUS_ACK = 2'b01
	} rrdac_bus_state_t;
endpackage

// >>> src/rrdac_reg8.sv
// one 8-bit control register with write mask and reset value
`timescale 1ns/1ps
module rrdac_reg8 #(
	parameter logic [7:0] MASK = 8'hFF,
	parameter logic [7:0] RST = 8'h00
) (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic wr_en_i,
	input wire logic [7:0] wr_data_i,
	output logic [7:0] q_o
);
	logic [7:0] q_ff;
	logic [7:0] nxt_q;
	// masked bits never take a write and stay zero
	assign nxt_q = wr_en_i ? (wr_data_i & MASK) : q_ff;
	// register
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			q_ff <= RST;
		end else begin
			q_ff <= nxt_q;
		end
	end
	assign q_o = q_ff;
endmodule

// >>> src/rrdac_tap_decode.sv
// one-hot tap decode for the resistor ladder
`timescale 1ns/1ps
module rrdac_tap_decode #(
	parameter int LEVELS = 32,
	parameter int CW = 5
) (
	input wire logic en_i,
	input wire logic [CW-1:0] code_i,
	output logic [LEVELS-1:0] tap_o
);
	// one tap per code, each code distinct
	genvar gi;
	generate
		for (gi = 0; gi < LEVELS; gi++) begin : g_tap
			assign tap_o[gi] = en_i && (code_i == CW'(gi));
		end
	endgenerate
endmodule

// >>> src/rrdac_ctrl.sv
// reference ladder control: registers, Avalon-MM slave, tap and switch outputs
// ----------------------------------------------------------------
// Functional notes
// - ladder runs only while enable set
// - 32 levels, each code a distinct tap
// - output is ground plus span times code/32
// - disabled, lps, all ones clamps to positive
// - disabled, no lps, zeros clamps to negative
// - positive source supply, ext pin, fixed ref
// - level routed to comparator, adc, pin, sense
// - pin gets level only when output enabled
// - pin output enable kills digital driver, input
// - pin port read returns zero while reference
// - lps set disconnects negative source
// - lps clear disconnects positive source
// - unimplemented bits ignore writes, read zero
// - source select decode, 11 reserved
// - reset disables ladder, pin, clears code
// - wake from sleep keeps control register
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "rrdac_defs.svh"
module rrdac_ctrl
	import rrdac_pkg::*;
#(
	parameter int LEVELS = `RRDAC_LEVELS,
	parameter int CW = 5
) (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic pin_port_in_i,
	input wire logic pin_port_drive_i,
	output logic ladder_active_o,
	output logic [LEVELS-1:0] tap_sel_o,
	output logic pos_sw_supply_o,
	output logic pos_sw_extref_o,
	output logic pos_sw_fixref_o,
	output logic neg_sw_ground_o,
	output logic clamp_pos_o,
	output logic clamp_neg_o,
	output logic route_cmp_o,
	output logic route_adc_o,
	output logic route_sense_o,
	output logic ref_output_pin_o,
	output logic pin_dig_drv_en_n_o,
	output logic pin_dig_in_en_o,
	output logic pin_port_read_o
);
	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	rrdac_bus_state_t state_ff;
	rrdac_bus_state_t nxt_state;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic req;
	logic sel_ctrl;
	logic sel_level;
	logic wr_ctrl;
	logic wr_level;
	logic [7:0] ctrl_q;
	logic [7:0] level_q;
	logic wait_ff;
	// address decode; unmapped reads give zero, writes are dropped
	assign req = (avs_read_i || avs_write_i) && (state_ff == RRDAC_BUS_IDLE);
	assign sel_ctrl = (avs_address_i == `RRDAC_OFS_CONTROL);
	assign sel_level = (avs_address_i == `RRDAC_OFS_LEVEL);
	assign wr_ctrl = req && avs_write_i && sel_ctrl && avs_byteenable_i[0];
	assign wr_level = req && avs_write_i && sel_level && avs_byteenable_i[0];
	assign nxt_state = req ? RRDAC_BUS_ACK : RRDAC_BUS_IDLE;
	assign nxt_rdata = (req && avs_read_i) ?
		(sel_ctrl ? {24'h000000, ctrl_q} : sel_level ? {24'h000000, level_q} : 32'h00000000) : rdata_ff;
	// one wait cycle, then waitrequest drops for one cycle with data
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			state_ff <= RRDAC_BUS_IDLE;
			rdata_ff <= 32'h00000000;
			wait_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			rdata_ff <= nxt_rdata;
			wait_ff <= !req;  // low only in the cycle after a request is taken
		end
	end
	// waitrequest from its own flop so the bus sees no decode glitch
	assign avs_readdata_o = rdata_ff;
	assign avs_waitrequest_o = wait_ff;
	// ----------------------------------------------------------------
	// registers (reset clears all; otherwise only bus writes change them)
	// ----------------------------------------------------------------
	rrdac_reg8 #(.MASK(`RRDAC_CONTROL_MASK), .RST(`RRDAC_CONTROL_RST)) u_ctrl (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.wr_en_i(wr_ctrl),
		.wr_data_i(avs_writedata_i[7:0]),
		.q_o(ctrl_q)
	);
	rrdac_reg8 #(.MASK(`RRDAC_LEVEL_MASK), .RST(`RRDAC_LEVEL_RST)) u_level (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.wr_en_i(wr_level),
		.wr_data_i(avs_writedata_i[7:0]),
		.q_o(level_q)
	);
	// ----------------------------------------------------------------
	// field extraction and derived switches
	// ----------------------------------------------------------------
	logic [7:0] ctrl_nx;
	logic [7:0] level_nx;
	logic en;
	logic lps;
	logic oe;
	rrdac_src_t pss;
	logic [CW-1:0] code;
	logic clamp_pos;
	logic clamp_neg;
	logic [LEVELS-1:0] taps;
	// register contents as they stand after this edge, so the output flops
	// change together with the register write instead of one cycle later
	assign ctrl_nx = wr_ctrl ? (avs_writedata_i[7:0] & `RRDAC_CONTROL_MASK) : ctrl_q;
	assign level_nx = wr_level ? (avs_writedata_i[7:0] & `RRDAC_LEVEL_MASK) : level_q;
	assign en = ctrl_nx[`RRDAC_BIT_ENABLE];
	assign lps = ctrl_nx[`RRDAC_BIT_LPS];
	assign oe = ctrl_nx[`RRDAC_BIT_OE];
	assign pss = rrdac_src_t'(ctrl_nx[`RRDAC_PSS_HI:`RRDAC_PSS_LO]);
	assign code = level_nx[CW-1:0];
	assign clamp_pos = !en && lps && (code == `RRDAC_CODE_ONES);
	assign clamp_neg = !en && !lps && (code == `RRDAC_CODE_ZERO);
	// tap k gives ground + span * k / 32
	rrdac_tap_decode #(.LEVELS(LEVELS), .CW(CW)) u_tap (
		.en_i(en),
		.code_i(code),
		.tap_o(taps)
	);
	// ----------------------------------------------------------------
	// source switch selection
	// ----------------------------------------------------------------
	logic pos_end_on;
	logic nxt_pos_supply;
	logic nxt_pos_extref;
	logic nxt_pos_fixref;
	logic nxt_neg_ground;
	// positive end open when lps clear, reserved code connects nothing
	assign pos_end_on = (en || clamp_pos) && lps;
	assign nxt_pos_supply = pos_end_on && (pss == RRDAC_SRC_SUPPLY);
	assign nxt_pos_extref = pos_end_on && (pss == RRDAC_SRC_EXTREF);
	assign nxt_pos_fixref = pos_end_on && (pss == RRDAC_SRC_FIXREF);
	// negative end is ground and opens when lps set
	assign nxt_neg_ground = (en || clamp_neg) && !lps;
	// ladder enable, tap and clamp flops load the post-write register view
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			ladder_active_o <= 1'b0;
			tap_sel_o <= '0;
			clamp_pos_o <= 1'b0;
			clamp_neg_o <= 1'b0;
		end else begin
			ladder_active_o <= en;
			tap_sel_o <= taps;
			clamp_pos_o <= clamp_pos;
			clamp_neg_o <= clamp_neg;
		end
	end
	// source switch flops
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			pos_sw_supply_o <= 1'b0;
			pos_sw_extref_o <= 1'b0;
			pos_sw_fixref_o <= 1'b0;
			neg_sw_ground_o <= 1'b0;
		end else begin
			pos_sw_supply_o <= nxt_pos_supply;
			pos_sw_extref_o <= nxt_pos_extref;
			pos_sw_fixref_o <= nxt_pos_fixref;
			neg_sw_ground_o <= nxt_neg_ground;
		end
	end
	// ----------------------------------------------------------------
	// routing and output pin override
	// ----------------------------------------------------------------
	logic level_valid;
	logic nxt_drv_en_n;
	logic nxt_port_read;
	// a level is defined while the ladder runs or a clamp holds the output
	assign level_valid = en || clamp_pos || clamp_neg;
	// the reference on the pin overrides the port's digital driver and input
	assign nxt_drv_en_n = oe || !pin_port_drive_i;
	assign nxt_port_read = oe ? 1'b0 : pin_port_in_i;
	// consumer routing flops
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			route_cmp_o <= 1'b0;
			route_adc_o <= 1'b0;
			route_sense_o <= 1'b0;
		end else begin
			route_cmp_o <= level_valid;
			route_adc_o <= level_valid;
			route_sense_o <= level_valid;
		end
	end
	// pin override flops
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			ref_output_pin_o <= 1'b0;
			pin_dig_drv_en_n_o <= 1'b1;
			pin_dig_in_en_o <= 1'b1;
			pin_port_read_o <= 1'b0;
		end else begin
			ref_output_pin_o <= oe;
			pin_dig_drv_en_n_o <= nxt_drv_en_n;
			pin_dig_in_en_o <= !oe;
			pin_port_read_o <= nxt_port_read;
		end
	end
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_ladder_off;
		@(posedge core_clk_i) disable iff (srst_i) !$past(en) |-> (tap_sel_o == '0);
	endproperty
	a_ladder_off: assert property (p_ladder_off) else $error("tap active while disabled");
	property p_tap_code;
		@(posedge core_clk_i) disable iff (srst_i) $past(en) |-> (tap_sel_o == (32'h1 << $past(code)));
	endproperty
	a_tap_code: assert property (p_tap_code) else $error("tap does not match code");
	property p_onehot;
		@(posedge core_clk_i) disable iff (srst_i) $onehot0(tap_sel_o);
	endproperty
	a_onehot: assert property (p_onehot) else $error("more than one tap");
	property p_clamp_pos;
		@(posedge core_clk_i) disable iff (srst_i)
			(!en && lps && code == 5'h1F && pss == RRDAC_SRC_SUPPLY) |=> (clamp_pos_o && pos_sw_supply_o);
	endproperty
	a_clamp_pos: assert property (p_clamp_pos) else $error("positive clamp missing");
	property p_clamp_neg;
		@(posedge core_clk_i) disable iff (srst_i) (!en && !lps && code == 5'h00) |=> (clamp_neg_o && neg_sw_ground_o);
	endproperty
	a_clamp_neg: assert property (p_clamp_neg) else $error("negative clamp missing");
	property p_pin_oe;
		@(posedge core_clk_i) disable iff (srst_i) 1'b1 |=> (ref_output_pin_o == $past(oe));
	endproperty
	a_pin_oe: assert property (p_pin_oe) else $error("pin does not follow enable");
	property p_pin_read;
		@(posedge core_clk_i) disable iff (srst_i) ref_output_pin_o |-> (!pin_port_read_o && pin_dig_drv_en_n_o && !pin_dig_in_en_o);
	endproperty
	a_pin_read: assert property (p_pin_read) else $error("digital path active on reference pin");
	property p_lps_neg;
		@(posedge core_clk_i) disable iff (srst_i) $past(lps) |-> !neg_sw_ground_o;
	endproperty
	a_lps_neg: assert property (p_lps_neg) else $error("negative source connected under lps");
	property p_lps_pos;
		@(posedge core_clk_i) disable iff (srst_i) !$past(lps) |-> !(pos_sw_supply_o || pos_sw_extref_o || pos_sw_fixref_o);
	endproperty
	a_lps_pos: assert property (p_lps_pos) else $error("positive source connected without lps");
	property p_unimpl;
		@(posedge core_clk_i) disable iff (srst_i) ((ctrl_q & 8'h13) == 8'h00) && ((level_q & 8'hE0) == 8'h00);
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");
	property p_reset;
		@(posedge core_clk_i) srst_i |=> (!ladder_active_o && !ref_output_pin_o && level_q == 8'h00);
	endproperty
	a_reset: assert property (p_reset) else $error("reset did not clear");
	property p_src_sel;
		@(posedge core_clk_i) disable iff (srst_i)
			(en && lps && pss == RRDAC_SRC_FIXREF) |=> (pos_sw_fixref_o && !neg_sw_ground_o);
	endproperty
	a_src_sel: assert property (p_src_sel) else $error("fixed reference source not selected");
	property p_src_rsvd;
		@(posedge core_clk_i) disable iff (srst_i)
			(pss == RRDAC_SRC_RSVD) |=> !(pos_sw_supply_o || pos_sw_extref_o || pos_sw_fixref_o);
	endproperty
	a_src_rsvd: assert property (p_src_rsvd) else $error("reserved source select connects a switch");
	property p_route;
		@(posedge core_clk_i) disable iff (srst_i) level_valid |=> (route_cmp_o && route_adc_o && route_sense_o);
	endproperty
	a_route: assert property (p_route) else $error("defined level not routed");
	property p_keep;
		@(posedge core_clk_i) disable iff (srst_i) !wr_ctrl |=> $stable(ctrl_q);
	endproperty
	a_keep: assert property (p_keep) else $error("control register changed without a write");
	property p_clamp_off;
		@(posedge core_clk_i) disable iff (srst_i) en |=> !(clamp_pos_o || clamp_neg_o);
	endproperty
	a_clamp_off: assert property (p_clamp_off) else $error("clamp active while ladder enabled");
	property p_pin_drv;
		@(posedge core_clk_i) disable iff (srst_i) oe |=> (pin_dig_drv_en_n_o && !pin_dig_in_en_o && !pin_port_read_o);
	endproperty
	a_pin_drv: assert property (p_pin_drv) else $error("digital pin path not overridden");
	property p_en_follow;
		@(posedge core_clk_i) disable iff (srst_i) wr_ctrl |=> (ladder_active_o == ctrl_q[`RRDAC_BIT_ENABLE]);
	endproperty
	a_en_follow: assert property (p_en_follow) else $error("ladder enable lags the register write");
	property p_oe_follow;
		@(posedge core_clk_i) disable iff (srst_i) wr_ctrl |=> (ref_output_pin_o == ctrl_q[`RRDAC_BIT_OE]);
	endproperty
	a_oe_follow: assert property (p_oe_follow) else $error("pin enable lags the register write");
	c_enabled: cover property (@(posedge core_clk_i) disable iff (srst_i) ladder_active_o && tap_sel_o[31]);
	c_fixref: cover property (@(posedge core_clk_i) disable iff (srst_i) pos_sw_fixref_o);
	c_clamp_pos: cover property (@(posedge core_clk_i) disable iff (srst_i) clamp_pos_o);
	c_clamp_neg: cover property (@(posedge core_clk_i) disable iff (srst_i) clamp_neg_o);
	c_pin: cover property (@(posedge core_clk_i) disable iff (srst_i) ref_output_pin_o && route_adc_o);
endmodule

// >>> dv/rrdac_pad_model.sv
// pad model: digital level seen at the reference output pin
`timescale 1ns/1ps
module rrdac_pad_model (
	input wire logic ext_level_i,
	input wire logic drv_data_i,
	input wire logic drv_en_n_i,
	output logic pad_o
);
	// port driver wins while it is on, otherwise the outside level shows
	assign pad_o = drv_en_n_i ? ext_level_i : drv_data_i;
endmodule

// >>> dv/rrdac_ctrl_tb_top.sv
// self-checking bench for the reference ladder control
`timescale 1ns/1ps
`include "rrdac_defs.svh"
module rrdac_ctrl_tb_top;
	import rrdac_pkg::*;
	logic clk, srst, rd, wr, drive, pin_in, act, cpos, cneg, ssup, sext, sfix, sgnd, rcmp, radc, rsen, rpin, drvn, dien, prd, wq;
	logic [3:0] addr, be;
	logic [31:0] wdat, rdat, tap, tap_ack;
	logic [7:0] ctl_sh, lvl_sh;
	int n_mismatch, tests_run;
	rrdac_ctrl dut (.core_clk_i(clk), .srst_i(srst), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
		.pin_port_in_i(pin_in), .pin_port_drive_i(drive), .ladder_active_o(act), .tap_sel_o(tap),
		.pos_sw_supply_o(ssup), .pos_sw_extref_o(sext), .pos_sw_fixref_o(sfix), .neg_sw_ground_o(sgnd),
		.clamp_pos_o(cpos), .clamp_neg_o(cneg), .route_cmp_o(rcmp), .route_adc_o(radc), .route_sense_o(rsen),
		.ref_output_pin_o(rpin), .pin_dig_drv_en_n_o(drvn), .pin_dig_in_en_o(dien), .pin_port_read_o(prd));
	// outside level pulled high, port driver pulls low, so the read mask is visible
	rrdac_pad_model pad (.ext_level_i(1'b1), .drv_data_i(1'b0), .drv_en_n_i(drvn), .pad_o(pin_in));
	// ----------------------------------------------------------------
	// clock, compare and bus tasks
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one Avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] b,
		output logic [31:0] q);
		@(posedge clk);
		addr <= a;
		wdat <= {24'h0, d};
		be <= b;
		if (w) wr <= 1'b1;
		else rd <= 1'b1;
		do begin
			@(posedge clk);
		end while (wq !== 1'b0);
		q = rdat;
		tap_ack = tap;
		wr <= 1'b0;
		rd <= 1'b0;
		if (w && b[0] && a == `RRDAC_OFS_CONTROL) ctl_sh = d & `RRDAC_CONTROL_MASK;
		if (w && b[0] && a == `RRDAC_OFS_LEVEL) lvl_sh = d & `RRDAC_LEVEL_MASK;
	endtask
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 4'hF, q);
		chk(tap_ack, ctl_sh[7] ? (32'h1 << lvl_sh[4:0]) : 32'h0);
	endtask
	task automatic rreg(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, 4'hF, q);
		chk(q, exp);
	endtask
	// expected outputs worked out from the shadow registers
	task automatic chk_state;
		logic en, lp, oe, cp, cn;
		logic [4:0] c;
		logic [1:0] ps;
		repeat (2) @(posedge clk);
		@(negedge clk);
		en = ctl_sh[7];
		lp = ctl_sh[6];
		oe = ctl_sh[5];
		ps = ctl_sh[3:2];
		c = lvl_sh[4:0];
		cp = !en && lp && c == 5'h1F;
		cn = !en && !lp && c == 5'h00;
		chk(tap, en ? (32'h1 << c) : 32'h0);
		chk({act, cpos, cneg}, {en, cp, cn});
		chk({ssup, sext, sfix}, {3{lp && (en || cp)}} & {ps == 2'h0, ps == 2'h1, ps == 2'h2});
		chk(sgnd, !lp && (en || cn));
		chk({rcmp, radc, rsen}, {3{en || cp || cn}});
		chk({rpin, drvn, dien, prd}, {oe, oe || !drive, !oe, !oe && !drive});
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		chk_state();
		rreg(`RRDAC_OFS_CONTROL, 32'h0);
		rreg(`RRDAC_OFS_LEVEL, 32'h0);
	endtask
	// unimplemented bits, masked byte lane and unmapped place
	task automatic t_regs;
		logic [31:0] q;
		wreg(`RRDAC_OFS_CONTROL, 8'hFF);
		wreg(`RRDAC_OFS_LEVEL, 8'hFF);
		rreg(`RRDAC_OFS_CONTROL, 32'hEC);
		bus(1'b1, `RRDAC_OFS_LEVEL, 8'h05, 4'hE, q);
		wreg(4'h8, 8'hAA);
		rreg(4'h8, 32'h0);
		rreg(`RRDAC_OFS_LEVEL, 32'h1F);
		chk_state();
	endtask
	// every code with alternating side select and every source select
	task automatic t_taps;
		for (int i = 0; i < 32; i++) begin
			wreg(`RRDAC_OFS_CONTROL, {1'b1, i[0], 2'b00, i[2:1], 2'b00});
			wreg(`RRDAC_OFS_LEVEL, i[7:0]);
			chk_state();
		end
	endtask
	// clamp corners and their near misses
	task automatic t_clamp;
		logic [15:0] tbl [7];
		tbl = '{16'h0000, 16'h401F, 16'h441F, 16'h481F, 16'h401E, 16'h0001, 16'h2000};
		for (int i = 0; i < 7; i++) begin
			wreg(`RRDAC_OFS_CONTROL, tbl[i][15:8]);
			wreg(`RRDAC_OFS_LEVEL, tbl[i][7:0]);
			chk_state();
		end
	endtask
	// pin override against every port drive wish
	task automatic t_pin;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			drive <= i[0];
			wreg(`RRDAC_OFS_CONTROL, {2'b00, i[1], 5'h00});
			chk_state();
		end
	endtask
	// reset in mid-run clears the level and the pin
	task automatic t_rst;
		wreg(`RRDAC_OFS_CONTROL, 8'hA8);
		wreg(`RRDAC_OFS_LEVEL, 8'h11);
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		ctl_sh = 8'h00;
		lvl_sh = 8'h00;
		chk_state();
		rreg(`RRDAC_OFS_LEVEL, 32'h0);
	endtask
	task automatic complete_run;
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		{rd, wr, drive, addr, be, wdat, ctl_sh, lvl_sh} = '0;
		srst = 1'b1;
		n_mismatch = 0;
		tests_run = 0;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_regs();
		t_taps();
		t_clamp();
		t_pin();
		t_rst();
		complete_run();
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		complete_run();
	end
endmodule
